// ==== cfs_pkg.sv ====
// Purpose: shared constants and types for the converter fault supervisor
// Assumes: 25 MHz system clock
// Notes: register offsets are word indices on the plain register port
package cfs_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned HICCUP_PAUSE_US = 128;
    localparam int unsigned PG_DEGLITCH_US = 40;
    localparam int unsigned HICCUP_PAUSE_CYC = (HICCUP_PAUSE_US * (CLK_HZ / 1000000));
    localparam int unsigned PG_DEGLITCH_CYC = (PG_DEGLITCH_US * (CLK_HZ / 1000000));
    localparam int unsigned HICCUP_TRIP_CYCLES = 32;
    localparam int unsigned CURRENT_LIMITED_FLAG_FLAG_CYCLES = 4;
    localparam int CNT_W = 12;
    localparam int OCP_W = 6;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_STATE = 4'h2;

    // control register fields
    localparam int CTL_DISCH = 0;
    localparam int CTL_RETRY = 1;
    localparam int CTL_BLANK = 2;
    localparam int CTL_SINGLE = 3;
    localparam int CTL_SWEN = 4;
    localparam int CTL_FPWM = 5;
    localparam logic [7:0] CTL_RESET = 8'h10;

    // status register fields
    localparam int ST_HICCUP = 0;
    localparam int ST_CURRENT_LIMITED_FLAG = 1;
    localparam int ST_UV = 2;
    localparam int ST_OV = 3;
    localparam int ST_THERMAL_WARNING_FLAG = 4;
    localparam int ST_THERMAL_SHUTDOWN_FLAG = 5;

    typedef struct packed {
        logic supply_uv;      // supply below lockout threshold
        logic supply_ov;      // supply above lockout threshold
        logic hs_limit;       // high-side current limit reached
        logic ls_below;       // low-side current below its limit
        logic ls_sink_limit;  // low-side sinking limit exceeded
        logic out_under;      // output under window
        logic out_over;       // output over window
        logic temp_warn;      // above warning rise threshold
        logic temp_warn_clr;  // below warning recovery threshold
        logic temp_shut;      // above shutdown threshold
        logic temp_shut_clr;  // below shutdown recovery threshold
        logic cycle_start;    // one pulse per switching cycle
        logic ramp_active;    // voltage transition ramp in progress
        logic soft_start;     // soft start in progress
        logic enable_in;      // level seen on the shared enable line
    } cfs_flags_t;

    typedef enum logic [1:0] {
        CFS_OFF = 2'b00,
        CFS_RUN = 2'b01,
        CFS_PAUSE = 2'b11,
        CFS_LOCK = 2'b10
    } cfs_state_t;
endpackage

// ==== cfs_supervisor.sv ====
// Purpose: fault and status supervisor for a step-down converter
// Assumes: all flag inputs already synchronous to i_clk
// Notes: power-good and enable are open-drain, oe high pulls the line low
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - supply undervoltage stops switching, pulls enable low, discharges if enabled.
// - supply overvoltage stops switching, pulls enable low, discharges if enabled.
// - high-side overcurrent turns high side off, low side on, until low current low.
// - low-side sink limit turns both switches off till next cycle, forced-PWM only.
// - retry enabled: 32 limited cycles then 128 us pause, then new soft start.
// - entering pause sets retry flag and holds power-good low.
// - status read clears retry flag only when overload is gone.
// - retry disabled: keep limiting; flag set after four consecutive limited cycles.
// - status read clears current-limit flag only when overload is gone.
// - power-good is open-drain output in primary, soft-start input in secondary.
// - output outside 94..106 percent window is bad, deglitched 40 us.
// - output under and over events set their window flags.
// - status read clears window flags only once out-of-window has ended.
// - blanking bit set ignores window result during a voltage ramp.
// - power-good low in thermal shutdown, pause, disable, lockout, soft start.
// - all units pull power-good low at init; then only primary drives it.
// - secondary does not sink while power-good low, then forced-PWM always.
// - faulted secondary leaves power-good free and pulls enable low instead.
// - warning flag above 150 C; read clears it only below 130 C.
// - above 170 C stop, set flag, pull power-good low, enable low unless single.
// - below 150 C release enable and power-good and restart with soft start.
// - read clears shutdown flag only when temperature is below recovery level.
module cfs_supervisor
    import cfs_pkg::*;
(
    input wire logic i_clk,            // system clock
    input wire logic i_rst_n,          // async reset, active low
    input wire cfs_flags_t i_flags,    // power stage flags
    input wire logic i_secondary,      // strap: unit is stack secondary
    input wire logic i_pg_in,          // level on shared power-good line
    input wire logic [3:0] i_addr,     // register address
    input wire logic [7:0] i_wdata,    // write data
    input wire logic i_wr,             // write strobe
    input wire logic i_rd,             // read strobe
    output logic [7:0] o_rdata,        // read data, cycle after strobe
    output logic o_switch_en,          // switching allowed
    output logic o_soft_start_req,     // pulse: begin new soft start
    output logic o_hs_on_allow,        // high-side switch may turn on
    output logic o_ls_force_on,        // low-side switch forced on
    output logic o_both_off,           // both switches held off
    output logic o_sink_allow,         // low side may sink current
    output logic o_fpwm,               // forced-PWM operation
    output logic o_discharge,          // output discharge on
    output logic o_pg_out,             // power-good drive level (always 0)
    output logic o_pg_oe,              // power-good pulled low
    output logic o_en_out,             // enable drive level (always 0)
    output logic o_en_oe               // enable pulled low
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [7:0] ctl_q;
    logic [5:0] status_q;
    logic [5:0] status_d;
    cfs_state_t state_q;
    logic [OCP_W-1:0] ocp_cnt_q;
    logic [CNT_W-1:0] pause_cnt_q;
    logic [CNT_W-1:0] dg_cnt_q;
    logic pg_good_q;
    logic thermal_shutdown_flag_q;
    logic hs_off_q;
    logic both_off_q;
    logic init_q;
    logic sec_pg_seen_q;
    logic lockout;
    logic win_bad;
    logic overload;
    logic hiccup_trip;
    logic pg_force_low;
    logic [7:0] rdata_q;
    logic ss_req_q;

    function automatic logic clr_ok(input logic flag, input logic cond_gone, input logic rd);
        clr_ok = flag && rd && cond_gone;
    endfunction

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign lockout = i_flags.supply_uv || i_flags.supply_ov;
    assign overload = i_flags.hs_limit;
    assign win_bad = (i_flags.out_under || i_flags.out_over)
                     && !(ctl_q[CTL_BLANK] && i_flags.ramp_active);
    assign hiccup_trip = ctl_q[CTL_RETRY] && i_flags.cycle_start && overload
                         && (ocp_cnt_q == OCP_W'(HICCUP_TRIP_CYCLES - 1));

    // register writes
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= CTL_RESET;
        end else if (i_wr && i_addr == ADDR_CTRL) begin
            ctl_q <= i_wdata;
        end
    end

    // consecutive limited-cycle counter, one step per switching cycle
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ocp_cnt_q <= '0;
        end else if (state_q != CFS_RUN) begin
            ocp_cnt_q <= '0;
        end else if (i_flags.cycle_start) begin
            if (!overload || hiccup_trip) begin
                ocp_cnt_q <= '0;
            end else if (ocp_cnt_q != '1) begin
                ocp_cnt_q <= ocp_cnt_q + OCP_W'(1);
            end
        end
    end

    // thermal shutdown with hysteresis
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            thermal_shutdown_flag_q <= 1'b0;
        end else if (i_flags.temp_shut) begin
            thermal_shutdown_flag_q <= 1'b1;
        end else if (i_flags.temp_shut_clr) begin
            thermal_shutdown_flag_q <= 1'b0;
        end
    end

    // operating state
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CFS_OFF;
            pause_cnt_q <= '0;
            ss_req_q <= 1'b0;
        end else begin
            ss_req_q <= 1'b0;
            case (state_q)
                CFS_OFF: begin
                    if (lockout || thermal_shutdown_flag_q) begin
                        state_q <= CFS_LOCK;
                    end else if (ctl_q[CTL_SWEN] && i_flags.enable_in) begin
                        state_q <= CFS_RUN;
                        ss_req_q <= 1'b1;
                    end
                end
                CFS_RUN: begin
                    if (lockout || thermal_shutdown_flag_q) begin
                        state_q <= CFS_LOCK;
                    end else if (!ctl_q[CTL_SWEN] || !i_flags.enable_in) begin
                        state_q <= CFS_OFF;
                    end else if (hiccup_trip) begin
                        state_q <= CFS_PAUSE;
                        pause_cnt_q <= CNT_W'(HICCUP_PAUSE_CYC - 1);
                    end
                end
                CFS_PAUSE: begin
                    if (lockout || thermal_shutdown_flag_q) begin
                        state_q <= CFS_LOCK;
                    end else if (pause_cnt_q == '0) begin
                        state_q <= CFS_OFF;
                    end else begin
                        pause_cnt_q <= pause_cnt_q - CNT_W'(1);
                    end
                end
                CFS_LOCK: begin
                    if (!lockout && !thermal_shutdown_flag_q) begin
                        state_q <= CFS_OFF;
                    end
                end
                default: begin
                    state_q <= CFS_OFF;
                end
            endcase
        end
    end

    // cycle-by-cycle current limit and sink limit
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_off_q <= 1'b0;
            both_off_q <= 1'b0;
        end else begin
            if (overload) begin
                hs_off_q <= 1'b1;
            end else if (i_flags.ls_below) begin
                hs_off_q <= 1'b0;
            end
            if (i_flags.cycle_start) begin
                both_off_q <= 1'b0;
            end else if (i_flags.ls_sink_limit && o_fpwm) begin
                both_off_q <= 1'b1;
            end
        end
    end

    // power-good deglitch
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            dg_cnt_q <= '0;
            pg_good_q <= 1'b0;
        end else if (win_bad == pg_good_q) begin
            if (dg_cnt_q == CNT_W'(PG_DEGLITCH_CYC - 1)) begin
                pg_good_q <= !win_bad;
                dg_cnt_q <= '0;
            end else begin
                dg_cnt_q <= dg_cnt_q + CNT_W'(1);
            end
        end else begin
            dg_cnt_q <= '0;
        end
    end

    // initialization and secondary power-good tracking
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_q <= 1'b1;
            sec_pg_seen_q <= 1'b0;
        end else begin
            init_q <= 1'b0;
            if (state_q != CFS_RUN) begin
                sec_pg_seen_q <= 1'b0;
            end else if (i_pg_in) begin
                sec_pg_seen_q <= 1'b1;
            end
        end
    end

    // sticky status, set wins over read clear
    always_comb begin
        status_d = status_q;
        if (i_rd && i_addr == ADDR_STATUS) begin
            if (clr_ok(status_q[ST_HICCUP], !overload, 1'b1)) status_d[ST_HICCUP] = 1'b0;
            if (clr_ok(status_q[ST_CURRENT_LIMITED_FLAG], !overload, 1'b1)) status_d[ST_CURRENT_LIMITED_FLAG] = 1'b0;
            if (clr_ok(status_q[ST_UV] || status_q[ST_OV], !win_bad, 1'b1)) begin
                status_d[ST_UV] = 1'b0;
                status_d[ST_OV] = 1'b0;
            end
            if (clr_ok(status_q[ST_THERMAL_WARNING_FLAG], i_flags.temp_warn_clr, 1'b1)) begin
                status_d[ST_THERMAL_WARNING_FLAG] = 1'b0;
            end
            if (clr_ok(status_q[ST_THERMAL_SHUTDOWN_FLAG], i_flags.temp_shut_clr, 1'b1)) begin
                status_d[ST_THERMAL_SHUTDOWN_FLAG] = 1'b0;
            end
        end
        if (hiccup_trip) status_d[ST_HICCUP] = 1'b1;
        if (!ctl_q[CTL_RETRY] && ocp_cnt_q >= OCP_W'(CURRENT_LIMITED_FLAG_FLAG_CYCLES)) begin
            status_d[ST_CURRENT_LIMITED_FLAG] = 1'b1;
        end
        if (i_flags.out_under) status_d[ST_UV] = 1'b1;
        if (i_flags.out_over) status_d[ST_OV] = 1'b1;
        if (i_flags.temp_warn) status_d[ST_THERMAL_WARNING_FLAG] = 1'b1;
        if (i_flags.temp_shut) status_d[ST_THERMAL_SHUTDOWN_FLAG] = 1'b1;
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    // read data, valid the cycle after the strobe
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_CTRL: rdata_q <= ctl_q;
                ADDR_STATUS: rdata_q <= {2'h0, status_q};
                ADDR_STATE: rdata_q <= {5'h00, pg_good_q, state_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign pg_force_low = thermal_shutdown_flag_q || lockout || state_q != CFS_RUN
                          || i_flags.soft_start || !i_flags.enable_in;
    assign o_rdata = rdata_q;
    assign o_switch_en = (state_q == CFS_RUN);
    assign o_soft_start_req = ss_req_q;
    assign o_hs_on_allow = o_switch_en && !hs_off_q && !both_off_q;
    assign o_ls_force_on = o_switch_en && hs_off_q && !both_off_q;
    assign o_both_off = both_off_q || !o_switch_en;
    assign o_sink_allow = !i_secondary || sec_pg_seen_q;
    assign o_fpwm = ctl_q[CTL_FPWM] || (i_secondary && sec_pg_seen_q);
    assign o_discharge = (state_q == CFS_LOCK || state_q == CFS_OFF)
                         && (ctl_q[CTL_DISCH] || i_secondary);
    assign o_pg_out = 1'b0;
    assign o_pg_oe = init_q || (!i_secondary && (pg_force_low || !pg_good_q));
    assign o_en_out = 1'b0;
    assign o_en_oe = lockout || (thermal_shutdown_flag_q && !ctl_q[CTL_SINGLE]);
endmodule

// ==== cfs_supervisor_monitor.sv ====
// Purpose: port-level checks on the fault supervisor
// Assumes: one clock domain, i_rst_n active low
// Notes: bound to every supervisor instance
`timescale 1ns/1ps
module cfs_supervisor_monitor
    import cfs_pkg::*;
(
    input wire logic i_clk, i_rst_n, i_secondary, i_pg_in, i_rd, // clock, reset, strap, bus
    input wire cfs_flags_t i_flags, // power stage flags
    input wire logic [7:0] o_rdata, // read data
    input wire logic o_switch_en, o_soft_start_req, o_hs_on_allow, o_ls_force_on, // stage
    input wire logic o_both_off, o_sink_allow, o_fpwm, o_discharge, o_pg_oe, o_en_oe // lines
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_uv_stop; i_flags.supply_uv [*2] |-> !o_switch_en; endproperty
    a_uv_stop: assert property (p_uv_stop) else $error("switching under low supply");
    property p_ov_en; i_flags.supply_ov |-> o_en_oe; endproperty
    a_ov_en: assert property (p_ov_en) else $error("enable not pulled on high supply");
    property p_disch; o_discharge |-> !o_switch_en; endproperty
    a_disch: assert property (p_disch) else $error("discharge while switching");
    property p_ss; $rose(o_switch_en) |-> ##[0:1] o_soft_start_req; endproperty
    a_ss: assert property (p_ss) else $error("restart without soft start");
    property p_sec_pg; i_secondary && o_switch_en |-> !o_pg_oe; endproperty
    a_sec_pg: assert property (p_sec_pg) else $error("secondary drives power-good");
    property p_pg_low; !i_secondary && !o_switch_en |-> ##[0:1] o_pg_oe; endproperty
    a_pg_low: assert property (p_pg_low) else $error("power-good free while stopped");
    property p_sink; i_secondary && !i_pg_in |-> !o_sink_allow; endproperty
    a_sink: assert property (p_sink) else $error("secondary sinks before power-good");
    property p_ocp;
        i_flags.hs_limit && !i_flags.ls_below && o_switch_en
            |-> ##[0:1] (!o_hs_on_allow && o_ls_force_on);
    endproperty
    a_ocp: assert property (p_ocp) else $error("high side not cut on overcurrent");
    property p_ls_off; i_flags.ls_sink_limit && o_fpwm |-> ##[0:1] o_both_off; endproperty
    a_ls_off: assert property (p_ls_off) else $error("switches on past sink limit");
    property p_rd; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("read data outside answer cycle");
    c_start: cover property ($rose(o_switch_en));
    c_en: cover property (o_en_oe && !o_switch_en);
    c_lim: cover property (i_flags.hs_limit && i_flags.cycle_start && o_switch_en);
endmodule
bind cfs_supervisor cfs_supervisor_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_secondary(i_secondary), .i_pg_in(i_pg_in), .i_rd(i_rd), .i_flags(i_flags),
    .o_rdata(o_rdata), .o_switch_en(o_switch_en), .o_soft_start_req(o_soft_start_req),
    .o_hs_on_allow(o_hs_on_allow), .o_ls_force_on(o_ls_force_on), .o_both_off(o_both_off),
    .o_sink_allow(o_sink_allow), .o_fpwm(o_fpwm), .o_discharge(o_discharge),
    .o_pg_oe(o_pg_oe), .o_en_oe(o_en_oe));

// ==== cfs_peer_model.sv ====
// Purpose: another stack unit sharing enable and power-good
// Assumes: both lines have pull-ups
// Notes: peer pulls both lines low while starting up, only enable while faulted
`timescale 1ns/1ps
module cfs_peer_model (
    input wire logic i_clk, // system clock
    input wire logic i_init, i_fault, // peer starting up, peer faulted
    input wire logic i_dut_pg_oe, i_dut_en_oe, // pull-downs of the supervisor
    output logic o_pg_line, o_en_line // resolved line levels
);
    logic pg_oe_q = 1'b1;
    logic en_oe_q = 1'b1;
    always_ff @(posedge i_clk) begin
        pg_oe_q <= i_init;
        en_oe_q <= i_init | i_fault;
    end
    assign o_pg_line = !(pg_oe_q | i_dut_pg_oe);
    assign o_en_line = !(en_oe_q | i_dut_en_oe);
endmodule

// ==== tb.sv ====
// Purpose: self-checking bench for the fault supervisor
// Assumes: 25 MHz clock, peer model on the shared lines
// Notes: random overload run lengths from a fixed seed
`timescale 1ns/1ps
module tb
    import cfs_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, sec = 1'b0, wr = 1'b0, rd = 1'b0;
    logic peer_init = 1'b1, peer_fault = 1'b0, pg_line, en_line;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, rv;
    cfs_flags_t fl = '0, flags_w;
    logic sw, hs_on, ls_on, both_off, sink, fpwm, disch, pg_oe, en_oe;
    int mismatches = 0, samples_checked = 0, n;
    always #20 clk = ~clk;
    always_comb begin
        flags_w = fl;
        flags_w.enable_in = en_line;
    end
    cfs_supervisor dut (.i_clk(clk), .i_rst_n(rst_n), .i_flags(flags_w), .i_secondary(sec),
        .i_pg_in(pg_line), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_switch_en(sw), .o_soft_start_req(), .o_hs_on_allow(hs_on),
        .o_ls_force_on(ls_on), .o_both_off(both_off), .o_sink_allow(sink), .o_fpwm(fpwm),
        .o_discharge(disch), .o_pg_out(), .o_pg_oe(pg_oe), .o_en_out(), .o_en_oe(en_oe));
    cfs_peer_model peer (.i_clk(clk), .i_init(peer_init), .i_fault(peer_fault),
        .i_dut_pg_oe(pg_oe), .i_dut_en_oe(en_oe), .o_pg_line(pg_line), .o_en_line(en_line));
    function automatic logic [7:0] current_limited_flag_exp(input int cnt);
        return (cnt >= CURRENT_LIMITED_FLAG_FLAG_CYCLES) ? 8'h02 : 8'h00;
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic wait_sw(input logic v, input int lim);
        int k;
        k = 0;
        #1;
        while (sw !== v && k < lim) begin
            @(posedge clk);
            #1 k++;
        end
        chk({7'h0, sw}, {7'h0, v});
        if (sw !== v) tally_and_finish();
    endtask
    task automatic cyc(input logic h);
        @(posedge clk);
        fl.cycle_start <= 1'b1;
        fl.hs_limit <= h;
        @(posedge clk);
        fl.cycle_start <= 1'b0;
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    initial begin
        settle(100000);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h8723));
        settle(20);
        rst_n <= 1'b1;
        settle(4);
        rd_reg(ADDR_CTRL);
        chk(rv, CTL_RESET);
        rd_reg(4'h7);
        chk(rv, 8'h00);
        peer_init <= 1'b0;
        wr_reg(ADDR_CTRL, 8'h11);
        wait_sw(1'b1, 50);
        peer_fault <= 1'b1;
        wait_sw(1'b0, 10);
        settle(2);
        chk({7'h0, pg_oe}, 8'h01);
        peer_fault <= 1'b0;
        wait_sw(1'b1, 50);
        $display("start and stack fault done");
        for (int k = 0; k < 2; k++) begin
            if (k == 0) fl.supply_uv <= 1'b1;
            else fl.supply_ov <= 1'b1;
            wait_sw(1'b0, 4);
            chk({6'h0, en_oe, disch}, 8'h03);
            @(posedge clk);
            fl.supply_uv <= 1'b0;
            fl.supply_ov <= 1'b0;
            wait_sw(1'b1, 50);
        end
        $display("lockout done");
        for (int t = 0; t < 6; t++) begin
            n = (t == 0) ? 3 : (t == 1) ? 4 : $urandom_range(0, 7);
            repeat (n) cyc(1'b1);
            if (t == 1) chk({6'h0, hs_on, ls_on}, 8'h01);
            rd_reg(ADDR_STATUS);
            rd_reg(ADDR_STATUS);
            chk(rv & 8'h02, current_limited_flag_exp(n));
            cyc(1'b0);
            rd_reg(ADDR_STATUS);
            rd_reg(ADDR_STATUS);
            chk(rv & 8'h02, 8'h00);
        end
        fl.ls_below <= 1'b1;
        settle(3);
        chk({6'h0, hs_on, ls_on}, 8'h02);
        fl.ls_below <= 1'b0;
        $display("current limit done");
        wr_reg(ADDR_CTRL, 8'h13);
        repeat (HICCUP_TRIP_CYCLES - 1) cyc(1'b1);
        chk({7'h0, sw}, 8'h01);
        cyc(1'b1);
        wait_sw(1'b0, 3);
        fl.hs_limit <= 1'b0;
        settle(3);
        chk({7'h0, pg_oe}, 8'h01);
        settle(HICCUP_PAUSE_CYC - 50);
        chk({7'h0, sw}, 8'h00);
        wait_sw(1'b1, 100);
        rd_reg(ADDR_STATUS);
        chk(rv & 8'h01, 8'h01);
        rd_reg(ADDR_STATUS);
        chk(rv & 8'h01, 8'h00);
        $display("hiccup done");
        wr_reg(ADDR_CTRL, 8'h11);
        fl.temp_shut <= 1'b1;
        fl.temp_warn <= 1'b1;
        wait_sw(1'b0, 4);
        settle(2);
        chk({6'h0, en_oe, pg_oe}, 8'h03);
        rd_reg(ADDR_STATUS);
        rd_reg(ADDR_STATUS);
        chk(rv & 8'h30, 8'h30);
        fl.temp_shut <= 1'b0;
        fl.temp_shut_clr <= 1'b1;
        fl.temp_warn <= 1'b0;
        wait_sw(1'b1, 50);
        chk({7'h0, en_oe}, 8'h00);
        rd_reg(ADDR_STATUS);
        rd_reg(ADDR_STATUS);
        chk(rv & 8'h30, 8'h10);
        fl.temp_warn_clr <= 1'b1;
        rd_reg(ADDR_STATUS);
        rd_reg(ADDR_STATUS);
        chk(rv & 8'h30, 8'h00);
        $display("thermal done");
        for (int k = 0; k < 2; k++) begin
            fl.out_under <= (k == 0);
            fl.out_over <= (k == 1);
            rd_reg(ADDR_STATUS);
            rd_reg(ADDR_STATUS);
            chk(rv & 8'h0c, (k == 0) ? 8'h04 : 8'h08);
            fl.out_under <= 1'b0;
            fl.out_over <= 1'b0;
            rd_reg(ADDR_STATUS);
            rd_reg(ADDR_STATUS);
            chk(rv & 8'h0c, 8'h00);
        end
        $display("window flags done");
        wr_reg(ADDR_CTRL, 8'h15);
        fl.ramp_active <= 1'b1;
        fl.out_over <= 1'b1;
        settle(PG_DEGLITCH_CYC + 20);
        rd_reg(ADDR_STATE);
        chk(rv, 8'h05);
        chk({7'h0, pg_oe}, 8'h00);
        fl.soft_start <= 1'b1;
        settle(2);
        chk({7'h0, pg_oe}, 8'h01);
        fl.soft_start <= 1'b0;
        fl.ramp_active <= 1'b0;
        settle(PG_DEGLITCH_CYC - 10);
        rd_reg(ADDR_STATE);
        chk(rv, 8'h05);
        settle(20);
        rd_reg(ADDR_STATE);
        chk(rv, 8'h01);
        chk({7'h0, pg_oe}, 8'h01);
        fl.out_over <= 1'b0;
        $display("power-good window done");
        wr_reg(ADDR_CTRL, 8'h31);
        fl.ls_sink_limit <= 1'b1;
        settle(2);
        chk({7'h0, both_off}, 8'h01);
        fl.ls_sink_limit <= 1'b0;
        wr_reg(ADDR_CTRL, 8'h11);
        // strap is only valid from a fresh start, so restart as a secondary
        rst_n <= 1'b0;
        sec <= 1'b1;
        peer_init <= 1'b1;
        settle(2);
        chk({7'h0, pg_oe}, 8'h01);
        rst_n <= 1'b1;
        settle(4);
        chk({7'h0, pg_oe}, 8'h00);
        chk({7'h0, sink}, 8'h00);
        peer_init <= 1'b0;
        settle(6);
        chk({7'h0, fpwm}, 8'h01);
        chk({7'h0, sink}, 8'h01);
        $display("secondary done");
        tally_and_finish();
    end
endmodule
